/* File: rtl/bts_pkg.sv */
// shared constants and carrier types of the bit-set / bit-test / branch execution block
package bts_pkg;
	// =====================================================================
	// opcode fields
	localparam logic [3:0]  OPC_BIT_SET    = 4'h8;
	localparam logic [3:0]  OPC_BIT_TEST_C = 4'hb;
	localparam logic [4:0]  OPC_REL_BRANCH = 5'h1a;
	localparam int          OPC_HI         = 15;
	localparam int          BIT_IDX_HI     = 11;
	localparam int          BIT_IDX_LO     = 9;
	localparam int          ACCESS_POS     = 8;
	localparam int          OFFSET_W       = 11;
	// =====================================================================
	// data address map
	localparam logic [7:0]  LIT_OFFSET_MAX = 8'h5f;
	localparam logic [7:0]  ACCESS_LO_LIM  = 8'h60;
	localparam logic [13:0] ACCESS_HI_BASE = 14'h3f00;
	// =====================================================================
	// instruction cycle phases, one core clock each
	localparam logic [1:0]  PH_Q1 = 2'h0;
	localparam logic [1:0]  PH_Q2 = 2'h1;
	localparam logic [1:0]  PH_Q3 = 2'h2;
	localparam logic [1:0]  PH_Q4 = 2'h3;
	localparam logic [1:0]  BRANCH_FLUSH_CYC = 2'h1;
	localparam int          PC_STEP = 2;

	typedef enum logic [1:0] {OP_NONE, OP_BIT_SET, OP_BIT_TEST_C, OP_REL_BRANCH} bts_op_t;

	typedef struct packed {
		bts_op_t              op;
		logic [2:0]           bit_idx;
		logic                 access;
		logic [7:0]           f;
		logic [OFFSET_W-1:0]  offset;
	} bts_dec_t;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [13:0] addr;
		logic [7:0]  wdata;
	} bts_reg_req_t;
endpackage

/* File: rtl/bts_exec.sv */
// execution of the bit-set, bit-test-skip-if-clear and relative branch instructions
// Functional notes
// - bit set reads, sets bit, writes back
// - access flag zero selects fixed access bank
// - access flag one uses bank select register
// - extended set, low addresses use literal offset
// - test skips next instruction when bit clear
// - skip flushes prefetch, runs one nop cycle per word of next instruction (at least one)
// - branch loads pc+2+2n, two cycles
`timescale 1ns/1ns
module bts_exec
	import bts_pkg::*;
#(
	parameter int PC_W   = 21,
	parameter int BANK_W = 6
) (
	// clock and reset
	input  wire logic                core_clk_i,
	input  wire logic                reset_i,
	// instruction from the fetch unit
	input  wire logic                instr_valid_i,
	input  wire logic [15:0]         instr_i,
	input  wire logic [PC_W-1:0]     instr_pc_i,
	input  wire logic [1:0]          next_words_i,
	input  wire logic                ext_set_en_i,
	input  wire logic [BANK_W-1:0]   bank_select_reg_i,
	input  wire logic [13:0]         index_base_i,
	output logic                     instr_take_o,
	output logic [1:0]               phase_o,
	// data register file
	output bts_pkg::bts_reg_req_t    reg_req_o,
	input  wire logic [7:0]          reg_rdata_i,
	// program counter and pipeline
	output logic                     pc_load_o,
	output logic [PC_W-1:0]          pc_value_o,
	output logic                     flush_o,
	output logic                     nop_o
);
	import bts_pkg::*;

	typedef enum logic {ST_RUN, ST_FLUSH} bts_state_t;

	bts_state_t   state;
	logic [1:0]   phase;
	bts_dec_t     dec;
	logic [PC_W-1:0] pc_base;
	logic [1:0]   nop_left;

	// =====================================================================
	// decode
	wire [3:0]  opc_nib   = instr_i[OPC_HI -: 4];
	wire [7:0]  f_fld     = instr_i[7:0];
	wire        acc_fld   = instr_i[ACCESS_POS];
	wire        is_set    = opc_nib == OPC_BIT_SET;
	wire        is_test   = opc_nib == OPC_BIT_TEST_C;
	wire        is_bra    = instr_i[OPC_HI -: 5] == OPC_REL_BRANCH;
	wire        take      = instr_valid_i && phase == PH_Q1 && state == ST_RUN;
	wire bts_op_t dec_op  = is_set ? OP_BIT_SET : is_test ? OP_BIT_TEST_C :
	                        is_bra ? OP_REL_BRANCH : OP_NONE;

	// =====================================================================
	// data address formation
	wire        lit_mode   = ext_set_en_i && f_fld <= LIT_OFFSET_MAX;
	wire [13:0] lit_addr   = index_base_i + {6'h00, f_fld};
	wire [13:0] acc_addr   = (f_fld < ACCESS_LO_LIM) ? {6'h00, f_fld}
	                                                 : ACCESS_HI_BASE | {6'h00, f_fld};
	wire [13:0] bank_addr  = 14'({bank_select_reg_i, f_fld});
	wire [13:0] data_addr  = acc_fld ? bank_addr : lit_mode ? lit_addr : acc_addr;
	wire        reg_op     = dec_op == OP_BIT_SET || dec_op == OP_BIT_TEST_C;

	// =====================================================================
	// execute
	wire [7:0]      bit_mask  = 8'h01 << dec.bit_idx;
	wire            test_bit  = |(reg_rdata_i & bit_mask);
	wire            skip      = dec.op == OP_BIT_TEST_C && !test_bit;
	wire [1:0]      skip_cyc  = (next_words_i == 2'h0) ? 2'h1 : next_words_i;
	wire [PC_W-1:0] rel_off   = PC_W'({{(PC_W-OFFSET_W){dec.offset[OFFSET_W-1]}},
	                                   dec.offset} <<< 1);
	wire [PC_W-1:0] next_pc   = pc_base + PC_W'(PC_STEP) + rel_off;
	wire            redirect  = skip || dec.op == OP_REL_BRANCH;

	assign instr_take_o = take;
	assign phase_o      = phase;
	assign nop_o        = state == ST_FLUSH;

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			phase <= PH_Q1;
		end else begin
			phase <= phase + 2'h1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			dec     <= '0;
			pc_base <= '0;
		end else if (take) begin
			dec     <= '{op: dec_op, bit_idx: instr_i[BIT_IDX_HI:BIT_IDX_LO],
			             access: acc_fld, f: f_fld, offset: instr_i[OFFSET_W-1:0]};
			pc_base <= instr_pc_i;
		end else if (phase == PH_Q4) begin
			dec.op  <= OP_NONE;
		end
	end

	// register read in Q2, data back in Q3, write-back and redirect in Q4
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			reg_req_o <= '0;
		end else begin
			reg_req_o.rd <= take && reg_op;
			reg_req_o.wr <= phase == PH_Q3 && dec.op == OP_BIT_SET;
			if (take) begin
				reg_req_o.addr <= data_addr;
			end
			if (phase == PH_Q3) begin
				reg_req_o.wdata <= reg_rdata_i | bit_mask;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			pc_load_o  <= 1'b0;
			pc_value_o <= '0;
			flush_o    <= 1'b0;
		end else begin
			pc_load_o <= phase == PH_Q3 && dec.op == OP_REL_BRANCH;
			flush_o   <= phase == PH_Q3 && redirect;
			if (phase == PH_Q3) begin
				pc_value_o <= next_pc;
			end
		end
	end

	// whole nop instruction cycles follow a redirect; prefetched words are dropped
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			state    <= ST_RUN;
			nop_left <= '0;
		end else if (phase == PH_Q4) begin
			case (state)
				ST_RUN: begin
					if (flush_o) begin
						state    <= ST_FLUSH;
						nop_left <= (dec.op == OP_REL_BRANCH) ? BRANCH_FLUSH_CYC
						                                      : skip_cyc;
					end
				end
				ST_FLUSH: begin
					nop_left <= nop_left - 2'h1;
					if (nop_left == 2'h1) begin
						state <= ST_RUN;
					end
				end
				default: state <= ST_RUN;
			endcase
		end
	end

	// =====================================================================
	// checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	// nop cycles owed, caught at the edge where the redirect is committed
	logic [1:0] take_words;
	logic [3:0] nop_run;
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			nop_run    <= '0;
			take_words <= '0;
		end else begin
			nop_run <= nop_o ? nop_run + 4'h1 : 4'h0;
			if (phase == PH_Q4 && flush_o) begin
				take_words <= (dec.op == OP_REL_BRANCH) ? BRANCH_FLUSH_CYC
				            : (next_words_i == 2'h0) ? 2'h1 : next_words_i;
			end
		end
	end

	sequence s_take_set;
		take && is_set;
	endsequence
	sequence s_take_skip;
		take && is_test;
	endsequence

	bit_set_wb_a: assert property (s_take_set |-> ##1 reg_req_o.rd ##2
		(reg_req_o.wr && reg_req_o.wdata == ($past(reg_rdata_i) | bit_mask)))
		else $error("bit set write-back wrong");
	access_bank_a: assert property (take && reg_op && !acc_fld && !lit_mode
		|=> reg_req_o.addr == {($past(f_fld) >= ACCESS_LO_LIM) ? 6'h3f : 6'h00, $past(f_fld)})
		else $error("access bank address wrong");
	bank_sel_a: assert property (take && reg_op && acc_fld
		|=> reg_req_o.addr == 14'({$past(bank_select_reg_i), $past(f_fld)}))
		else $error("banked address wrong");
	lit_offset_a: assert property (take && reg_op && !acc_fld && ext_set_en_i
		&& f_fld <= LIT_OFFSET_MAX |=> reg_req_o.addr == $past(index_base_i) + {6'h00, $past(f_fld)})
		else $error("literal offset address wrong");
	skip_clear_a: assert property (s_take_skip ##2 !(|(reg_rdata_i & bit_mask))
		|=> flush_o)
		else $error("clear bit did not skip");
	no_skip_a: assert property (s_take_skip ##2 (|(reg_rdata_i & bit_mask))
		|=> !flush_o ##1 !nop_o)
		else $error("set bit skipped");
	flush_nop_a: assert property (flush_o |=> nop_o[*4])
		else $error("flush without nop cycle");
	branch_pc_a: assert property (take && is_bra |-> ##3 (pc_load_o
		&& pc_value_o == $past(instr_pc_i, 3) + PC_W'(PC_STEP)
		+ PC_W'({{(PC_W-OFFSET_W){$past(instr_i[OFFSET_W-1], 3)}},
		$past(instr_i[OFFSET_W-1:0], 3)} <<< 1)) ##1 nop_o[*4] ##1 !nop_o)
		else $error("branch target or length wrong");
	multi_word_a: assert property ($fell(nop_o)
		|-> nop_run == {take_words, 2'h0})
		else $error("nop count mismatch");
	set_one_cycle_a: assert property (s_take_set |-> ##3 (!flush_o && !pc_load_o)
		##1 !nop_o)
		else $error("bit set took more than one cycle");
	test_no_write_a: assert property (s_take_skip |-> ##3 !reg_req_o.wr)
		else $error("bit test wrote a register");
endmodule // bts_exec

/* File: tb/bts_regfile_model.sv */
// data register file model facing the execution block
`timescale 1ns/1ns
module bts_regfile_model
	import bts_pkg::*;
(
	// clock
	input  wire logic                  core_clk_i,
	// register access
	input  wire bts_pkg::bts_reg_req_t reg_req_i,
	output logic [7:0]                 reg_rdata_o = 8'h5a
);
	logic [7:0] mem [0:16383];
	// ========
	// storage
	// read data lasts one clock, then inverts so a late sample is caught
	always @(posedge core_clk_i) begin
		if (reg_req_i.rd)
			reg_rdata_o <= mem[reg_req_i.addr];
		else
			reg_rdata_o <= ~reg_rdata_o;
		if (reg_req_i.wr)
			mem[reg_req_i.addr] <= reg_req_i.wdata;
	end
endmodule // bts_regfile_model

/* File: tb/bit_set_test_skip_branch_exec_tb_top.sv */
// self-checking bench of the bit-set, test-skip and branch execution block
`timescale 1ns/1ns
module bit_set_test_skip_branch_exec_tb_top;
	import bts_pkg::*;
	logic         core_clk_i = 1'b0;
	logic         reset_i = 1'b1;
	logic         instr_valid_i = 1'b0;
	logic         ext_set_en_i = 1'b0;
	logic [15:0]  instr_i = 16'h0;
	logic [20:0]  instr_pc_i = 21'h0;
	logic [1:0]   next_words_i = 2'h1;
	logic [5:0]   bank_select_reg_i = 6'h0;
	logic [13:0]  index_base_i = 14'h0;
	logic [20:0]  pc_value_o, pc_seen;
	logic [1:0]   phase_o;
	logic [7:0]   reg_rdata_i, wdata_seen;
	logic         instr_take_o, pc_load_o, flush_o, nop_o;
	bts_reg_req_t reg_req_o;
	logic [19:0]  rd_m, wr_m, fl_m, pl_m, nop_m;
	logic [13:0]  addr_seen;
	int           bad_count = 0;
	int           checks_done = 0;
	// ========
	// design and partner
	bts_exec u_dut (.core_clk_i, .reset_i, .instr_valid_i, .instr_i, .instr_pc_i,
		.next_words_i, .ext_set_en_i, .bank_select_reg_i, .index_base_i, .instr_take_o,
		.phase_o, .reg_req_o, .reg_rdata_i, .pc_load_o, .pc_value_o, .flush_o, .nop_o);
	bts_regfile_model u_rf (.core_clk_i, .reg_req_i(reg_req_o), .reg_rdata_o(reg_rdata_i));
	// ========
	// helpers
	task automatic chk(input string what, input logic [31:0] ex, input logic [31:0] got);
		checks_done++;
		if (ex !== got) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, ex, got);
		end
	endtask
	// one instruction, then 19 clocks of outputs recorded as bit masks
	task automatic run(input logic [15:0] ins, input logic ext, input logic [5:0] bank_select_reg,
		input logic [1:0] nw, input logic [13:0] ib, input logic [20:0] pc);
		int n;
		n = 0;
		{rd_m, wr_m, fl_m, pl_m, nop_m} = '0;
		@(posedge core_clk_i);
		instr_valid_i <= 1'b1;
		instr_i <= ins;
		ext_set_en_i <= ext;
		bank_select_reg_i <= bank_select_reg;
		next_words_i <= nw;
		index_base_i <= ib;
		instr_pc_i <= pc;
		do begin
			@(negedge core_clk_i);
			n++;
		end while (instr_take_o !== 1'b1 && n < 40);
		chk("take", 1, instr_take_o);
		chk("phase", 0, phase_o);
		@(posedge core_clk_i);
		instr_valid_i <= 1'b0;
		for (int j = 1; j < 20; j++) begin
			@(negedge core_clk_i);
			rd_m[j] = reg_req_o.rd;
			wr_m[j] = reg_req_o.wr;
			fl_m[j] = flush_o;
			pl_m[j] = pc_load_o;
			nop_m[j] = nop_o;
			if (j == 1) addr_seen = reg_req_o.addr;
			if (j == 3) wdata_seen = reg_req_o.wdata;
			if (j == 3) pc_seen = pc_value_o;
		end
	endtask
	// ========
	// scenarios
	task automatic test_bit_set;
		logic [7:0]  f [6] = '{8'h34, 8'h20, 8'ha5, 8'h5f, 8'h60, 8'h20};
		logic [13:0] ad [6] = '{14'h0534, 14'h0020, 14'h3fa5, 14'h015f, 14'h3f60, 14'h0320};
		logic [2:0]  b;
		logic        a;
		for (int i = 0; i < 6; i++) begin
			b = 3'(7 - i);
			a = (i == 0 || i == 5);
			u_rf.mem[ad[i]] = 8'h0a;
			run({4'h8, b, a, f[i]}, i >= 3, (i == 0) ? 6'h05 : 6'h03, 2'h1, 14'h0100, 21'h0);
			chk("addr", ad[i], addr_seen);
			chk("rd", 20'h2, rd_m);
			chk("wr", 20'h8, wr_m);
			chk("wdata", 8'h0a | (8'h1 << b), wdata_seen);
			chk("stored", 8'h0a | (8'h1 << b), u_rf.mem[ad[i]]);
			chk("nop", 20'h0, nop_m | fl_m | pl_m);
		end
		$display("bit set test done");
	endtask
	task automatic test_skip;
		for (int i = 0; i < 4; i++) begin
			u_rf.mem[14'h0042] = (i == 0) ? 8'h10 : 8'hef;
			run({4'hb, 3'h4, 1'b1, 8'h42}, 1'b0, 6'h00, 2'(i), 14'h0, 21'h0);
			chk("addr", 14'h0042, addr_seen);
			chk("rd", 20'h2, rd_m | wr_m | pl_m);
			chk("flush", (i == 0) ? 20'h0 : 20'h8, fl_m);
			chk("nop", ((20'h1 << (4 * i)) - 20'h1) << 4, nop_m);
		end
		$display("skip test done");
	endtask
	task automatic test_branch;
		logic [10:0] n [3] = '{11'h7fd, 11'h3ff, 11'h400};
		logic [20:0] pc [3] = '{21'h100, 21'h10, 21'h1000};
		logic [20:0] ex [3] = '{21'hfc, 21'h810, 21'h802};
		for (int i = 0; i < 3; i++) begin
			run({5'h1a, n[i]}, 1'b0, 6'h0, 2'h1, 14'h0, pc[i]);
			chk("pc", ex[i], pc_seen);
			chk("pcload", 20'h8, pl_m | rd_m | wr_m);
			chk("flush", 20'h8, fl_m);
			chk("nop", 20'hf0, nop_m);
		end
		$display("branch test done");
	endtask
	// a request held high is refused until the flushed cycles end
	task automatic test_hold;
		int gap;
		for (int i = 0; i < 2; i++) begin
			u_rf.mem[14'h0042] = 8'hef;
			gap = 0;
			@(posedge core_clk_i);
			instr_valid_i <= 1'b1;
			instr_i <= (i == 0) ? {5'h1a, 11'h001} : {4'hb, 3'h4, 1'b1, 8'h42};
			bank_select_reg_i <= 6'h0;
			next_words_i <= 2'h3;
			do begin
				@(negedge core_clk_i);
				gap++;
			end while (instr_take_o !== 1'b1 && gap < 40);
			gap = 0;
			do begin
				@(negedge core_clk_i);
				gap++;
			end while (instr_take_o !== 1'b1 && gap < 40);
			chk("take gap", (i == 0) ? 8 : 16, gap);
			@(posedge core_clk_i);
			instr_valid_i <= 1'b0;
			repeat (20) @(posedge core_clk_i);
		end
		$display("hold test done");
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ========
	// clock, sequence and watchdog
	initial forever #2 core_clk_i = ~core_clk_i;
	initial begin
		repeat (16) @(posedge core_clk_i);
		reset_i <= 1'b0;
		test_bit_set;
		test_skip;
		test_branch;
		test_hold;
		give_verdict;
	end
	// tests need under 600 clocks; a hang stops well after that
	initial begin
		#40000;
		bad_count++;
		give_verdict;
	end
endmodule // bit_set_test_skip_branch_exec_tb_top
